// ==== design/sic_crc16.sv ====
// Byte-wide ModBus CRC16 accumulator
`include "sic_map.svh"
`default_nettype none
module sic_crc16 (
    input wire logic i_clk,
    input wire logic i_rst,
    input wire logic i_init,
    input wire logic i_feed,
    input wire logic [7:0] i_byte,
    output logic [15:0] o_crc
);
    // ------------------------------------------------------------------
    // One byte per cycle, LSB first, reflected polynomial
    // ------------------------------------------------------------------
    logic [15:0] crc_d;
    always_comb begin
        crc_d = o_crc ^ {8'h00, i_byte};
        for (int i = 0; i < 8; i++) begin
            crc_d = crc_d[0] ? ((crc_d >> 1) ^ `SIC_CRC_POLY) : (crc_d >> 1);
        end
    end
    // Init wins: a frame restarts at every START
    always_ff @(posedge i_clk) begin
        if (i_rst || i_init) begin
            o_crc <= `SIC_CRC_INIT;
        end else if (i_feed) begin
            o_crc <= crc_d;
        end
    end
endmodule : sic_crc16
`default_nettype wire

// ==== design/sic_i2c_slave.sv ====
// I2C command slave: frame receive, CRC check, reply transmit
`include "sic_map.svh"
`default_nettype none
module sic_i2c_slave import sic_pkg::*; #(
    parameter logic [6:0] P_DEFAULT_ADDR = `SIC_DEF_ADDR
) (
    input wire logic i_clk,
    input wire logic i_rst,
    input wire logic i_scl,            // Bus clock pin, from the master
    input wire logic i_sda,            // Bus data pin level
    output logic o_sda_o,              // Data driven, always low
    output logic o_sda_oe,             // High while pulling SDA low
    output logic o_wr_valid,           // Pulse per byte after address
    output logic [7:0] o_wr_byte,      // Byte received
    output logic o_frame_ok,           // Pulse: write frame, CRC good
    output logic o_frame_bad,          // Pulse: write frame, CRC bad
    output logic [7:0] o_cmd_code,     // Last command code
    output logic [6:0] o_addr,         // Address now answered
    output logic [7:0] o_rsp_idx,      // Reply data index wanted
    input wire logic [7:0] i_rsp_len,  // Reply bytes after code
    input wire logic [7:0] i_rsp_byte, // Reply byte at o_rsp_idx
    input wire logic i_rsp_err,        // Reply is an error reply
    input wire logic [7:0] i_rsp_exc   // Exception code, 1 to 127
);
    // ------------------------------------------------------------------
    // Elaboration check
    // ------------------------------------------------------------------
    // Address zero is the general call and cannot be ours
    if (P_DEFAULT_ADDR == 7'h00) begin : g_bad_addr
        $error("default slave address must not be zero");
    end
    // ------------------------------------------------------------------
    // Pin synchronisers and bus condition detect
    // ------------------------------------------------------------------
    logic [1:0] scl_s_q; // Two-stage synchroniser, SCL
    logic [1:0] sda_s_q; // Two-stage synchroniser, SDA
    logic scl_p_q;       // Previous synchronised SCL
    logic sda_p_q;       // Previous synchronised SDA
    always_ff @(posedge i_clk) begin
        scl_s_q <= {scl_s_q[0], i_scl};
        sda_s_q <= {sda_s_q[0], i_sda};
        scl_p_q <= scl_s_q[1];
        sda_p_q <= sda_s_q[1];
    end
    wire scl = scl_s_q[1];
    wire sda = sda_s_q[1];
    wire scl_rise = scl & ~scl_p_q;
    wire scl_fall = ~scl & scl_p_q;
    // SDA moving while SCL stays high marks START or STOP
    wire start = scl & scl_p_q & sda_p_q & ~sda;
    wire stop = scl & scl_p_q & ~sda_p_q & sda;
    wire busc = start | stop;
    // ------------------------------------------------------------------
    // State registers
    // ------------------------------------------------------------------
    sic_state_type state_q, state_d;
    logic [3:0] bit_q, bit_d;        // Bits moved in this byte
    logic [7:0] sh_q, sh_d;          // Shift register, MSB first
    logic rw_q, rw_d;                // Direction of this transfer
    logic wr_act_q, wr_act_d;        // A write frame is open
    logic [7:0] wr_idx_q, wr_idx_d;  // Bytes after address, saturates
    logic [8:0] rd_idx_q, rd_idx_d;  // Reply bytes already loaded
    logic ack_q, ack_d;              // Master acked the last reply byte
    logic [7:0] cmd_q, cmd_d;        // Command code byte
    logic [7:0] arg_q, arg_d;        // First byte after the code
    logic [6:0] addr_q, addr_d;      // Live slave address
    logic fail_q, fail_d;            // Last frame failed its check
    logic oe_d, wrv_d, ok_d, bad_d;
    logic feed;                      // Byte into the checksum
    logic [7:0] feed_byte;
    logic [15:0] crc;                // Running checksum
    // ------------------------------------------------------------------
    // Checksum over the whole frame, address byte included
    // ------------------------------------------------------------------
    sic_crc16 u_crc (
        .i_clk(i_clk),
        .i_rst(i_rst),
        .i_init(start),
        .i_feed(feed),
        .i_byte(feed_byte),
        .o_crc(crc)
    );
    // ------------------------------------------------------------------
    // Reply byte selection
    // ------------------------------------------------------------------
    wire rsp_err = fail_q | i_rsp_err;
    wire [7:0] exc = fail_q ? `SIC_EXC_CRC : i_rsp_exc;
    // An error reply always carries exactly one byte after the code
    wire [8:0] body_n = rsp_err ? 9'h001 : {1'b0, i_rsp_len};
    wire [7:0] code_b = rsp_err ? (cmd_q | `SIC_ERR_FLAG) : cmd_q;
    wire is_code = (rd_idx_q == 9'h000);
    wire is_body = ~is_code & (rd_idx_q <= body_n);
    wire is_crc_lo = (rd_idx_q == body_n + 9'h001);
    wire is_crc_hi = (rd_idx_q == body_n + 9'h002);
    // Past the trailer the bus just reads released (all ones)
    wire [7:0] tx_byte = is_code ? code_b :
                         is_body ? (rsp_err ? exc : i_rsp_byte) :
                         is_crc_lo ? crc[7:0] :
                         is_crc_hi ? crc[15:8] : `SIC_IDLE_BYTE;
    // Trailer bytes are not folded back into the sum they carry
    wire tx_feed = is_code | is_body;
    wire addr_hit = (sh_q[7:1] == addr_q);
    wire byte_end = scl_fall & (bit_q == `SIC_BYTE_BITS);
    // ------------------------------------------------------------------
    // End of write frame: judge the checksum
    // ------------------------------------------------------------------
    wire frame_end = busc & wr_act_q & (wr_idx_q != 8'h00);
    // Residue over data plus its own CRC is zero when intact
    wire frame_good = (wr_idx_q >= `SIC_MIN_FRAME) & (crc == 16'h0000);
    wire set_addr = frame_good & (cmd_q == `SIC_CMD_SETADDR) &
                    (wr_idx_q >= `SIC_ARG_FRAME) & (arg_q[6:0] != 7'h00);
    // ------------------------------------------------------------------
    // Sequencer next state
    // ------------------------------------------------------------------
    always_comb begin
        state_d = state_q;
        bit_d = bit_q;
        sh_d = sh_q;
        rw_d = rw_q;
        wr_act_d = wr_act_q;
        wr_idx_d = wr_idx_q;
        rd_idx_d = rd_idx_q;
        ack_d = ack_q;
        cmd_d = cmd_q;
        arg_d = arg_q;
        addr_d = addr_q;
        fail_d = fail_q;
        oe_d = o_sda_oe;
        wrv_d = 1'b0;
        ok_d = 1'b0;
        bad_d = 1'b0;
        feed = 1'b0;
        feed_byte = sh_q;
        // Every write frame with at least one byte after the address gets a verdict before anything else
        if (frame_end) begin
            ok_d = frame_good;
            bad_d = ~frame_good;
            fail_d = ~frame_good;
            if (set_addr) begin
                addr_d = arg_q[6:0];
            end
        end
        if (start) begin
            // Only ever follows the master; nothing here starts a transfer
            state_d = ST_ADDR;
            bit_d = 4'h0;
            oe_d = 1'b0;
            wr_act_d = 1'b0;
        end else if (stop) begin
            state_d = ST_IDLE;
            oe_d = 1'b0;
            wr_act_d = 1'b0;
        end else begin
            case (state_q)
                ST_IDLE: begin
                    oe_d = 1'b0;
                end
                ST_ADDR: begin
                    if (scl_rise) begin
                        sh_d = {sh_q[6:0], sda};
                        bit_d = bit_q + 4'h1;
                    end else if (byte_end) begin
                        if (addr_hit) begin
                            oe_d = 1'b1;
                            state_d = ST_ACK;
                            rw_d = sh_q[0];
                            wr_act_d = ~sh_q[0];
                            wr_idx_d = 8'h00;
                            rd_idx_d = 9'h000;
                            feed = 1'b1;
                        end else begin
                            state_d = ST_IDLE;
                        end
                    end
                end
                ST_ACK: begin
                    if (scl_fall) begin
                        bit_d = 4'h0;
                        if (rw_q) begin
                            // Reply byte goes out as the ack clock ends
                            sh_d = tx_byte;
                            oe_d = ~tx_byte[7];
                            feed = tx_feed;
                            feed_byte = tx_byte;
                            rd_idx_d = rd_idx_q + 9'h001;
                            state_d = ST_RD;
                        end else begin
                            oe_d = 1'b0;
                            state_d = ST_WR;
                        end
                    end
                end
                ST_WR: begin
                    if (scl_rise) begin
                        sh_d = {sh_q[6:0], sda};
                        bit_d = bit_q + 4'h1;
                    end else if (byte_end) begin
                        oe_d = 1'b1;
                        state_d = ST_ACK;
                        wrv_d = 1'b1;
                        feed = 1'b1;
                        if (wr_idx_q == 8'h00) begin
                            cmd_d = sh_q;
                        end
                        if (wr_idx_q == 8'h01) begin
                            arg_d = sh_q;
                        end
                        if (wr_idx_q != 8'hff) begin
                            wr_idx_d = wr_idx_q + 8'h01;
                        end
                    end
                end
                ST_RD: begin
                    if (scl_rise) begin
                        bit_d = bit_q + 4'h1;
                    end else if (byte_end) begin
                        oe_d = 1'b0;
                        state_d = ST_MACK;
                    end else if (scl_fall) begin
                        sh_d = {sh_q[6:0], 1'b1};
                        oe_d = ~sh_q[6];
                    end
                end
                ST_MACK: begin
                    if (scl_rise) begin
                        ack_d = ~sda;
                    end else if (scl_fall) begin
                        // Master left SDA high: it wants no more
                        state_d = ack_q ? ST_ACK : ST_IDLE;
                        oe_d = 1'b0;
                    end
                end
                default: begin
                    state_d = ST_IDLE;
                    oe_d = 1'b0;
                end
            endcase
        end
        // MACK falls straight into a reply load, skipping the ACK state
        if (state_q == ST_MACK && scl_fall && ack_q && !busc) begin
            bit_d = 4'h0;
            sh_d = tx_byte;
            oe_d = ~tx_byte[7];
            feed = tx_feed;
            feed_byte = tx_byte;
            rd_idx_d = rd_idx_q + 9'h001;
            state_d = ST_RD;
        end
    end
    // ------------------------------------------------------------------
    // Register update
    // ------------------------------------------------------------------
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            state_q <= ST_IDLE;
            bit_q <= 4'h0;
            sh_q <= 8'h00;
            rw_q <= 1'b0;
            wr_act_q <= 1'b0;
            wr_idx_q <= 8'h00;
            rd_idx_q <= 9'h000;
            ack_q <= 1'b0;
            cmd_q <= 8'h00;
            arg_q <= 8'h00;
            fail_q <= 1'b0;
        end else begin
            state_q <= state_d;
            bit_q <= bit_d;
            sh_q <= sh_d;
            rw_q <= rw_d;
            wr_act_q <= wr_act_d;
            wr_idx_q <= wr_idx_d;
            rd_idx_q <= rd_idx_d;
            ack_q <= ack_d;
            cmd_q <= cmd_d;
            arg_q <= arg_d;
            fail_q <= fail_d;
        end
    end
    // Address survives only until reset; a stored default is the parameter
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            addr_q <= P_DEFAULT_ADDR;
        end else begin
            addr_q <= addr_d;
        end
    end
    // Outputs, all registered
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            o_sda_o <= 1'b0;
            o_sda_oe <= 1'b0;
            o_wr_valid <= 1'b0;
            o_wr_byte <= 8'h00;
            o_frame_ok <= 1'b0;
            o_frame_bad <= 1'b0;
            o_rsp_idx <= 8'h00;
        end else begin
            o_sda_o <= 1'b0;
            o_sda_oe <= oe_d;
            o_wr_valid <= wrv_d;
            o_wr_byte <= wrv_d ? sh_q : o_wr_byte;
            o_frame_ok <= ok_d;
            o_frame_bad <= bad_d;
            o_rsp_idx <= rd_idx_d[7:0] - 8'h01;
        end
    end
    assign o_cmd_code = cmd_q;
    assign o_addr = addr_q;
    // ------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (i_rst);
    a_idle_no_drive: assert property (
        state_q == ST_IDLE |-> !o_sda_oe)
        else $error("SDA driven while idle");
    a_addr_hit_ack: assert property (
        state_q == ST_ADDR && byte_end && addr_hit && !busc
        |=> o_sda_oe && state_q == ST_ACK)
        else $error("own address not acked");
    a_addr_miss: assert property (
        state_q == ST_ADDR && byte_end && !addr_hit && !busc
        |=> !o_sda_oe [*2])
        else $error("foreign address acked");
    a_write_ack: assert property (
        state_q == ST_WR && byte_end && !busc
        |=> o_sda_oe && state_q == ST_ACK)
        else $error("write byte not acked");
    // The ack must hold through the whole ninth clock, high phase included
    a_ack_holds: assert property (
        state_q == ST_ACK |-> o_sda_oe)
        else $error("ack dropped early");
    a_ack_release: assert property (
        state_q == ST_ACK && !rw_q && scl_fall && !busc
        |=> !o_sda_oe && state_q == ST_WR)
        else $error("write ack not released");
    a_read_bit: assert property (
        state_q == ST_RD |-> o_sda_oe == ~sh_q[7])
        else $error("read bit not on SDA");
    a_err_code: assert property (
        state_q == ST_ACK && scl_fall && rw_q && rsp_err &&
        rd_idx_q == 9'h000 && !busc |=> sh_q == (cmd_q | `SIC_ERR_FLAG))
        else $error("error reply lacks flag");
    a_nack_release: assert property (
        state_q == ST_MACK && scl_fall && !ack_q && !busc
        |=> state_q == ST_IDLE && !o_sda_oe)
        else $error("reply continued after nack");
    a_crc_verdict: assert property (
        frame_end |=> o_frame_ok == $past(frame_good) &&
        o_frame_bad != o_frame_ok)
        else $error("frame verdict wrong");
    a_fail_sticky: assert property (
        frame_end && !frame_good |=> fail_q)
        else $error("bad frame not flagged");
    a_addr_change: assert property (
        frame_end && set_addr |=> addr_q == $past(arg_q[6:0]))
        else $error("address not changed");
    c_good_write: cover property (o_frame_ok);
    c_bad_write: cover property (o_frame_bad);
    c_read_reply: cover property (state_q == ST_MACK && is_crc_hi);
    c_new_addr: cover property (frame_end && set_addr);
endmodule : sic_i2c_slave
`default_nettype wire

// ==== pkg/sic_map.svh ====
// Constants of the switch I2C command slave, with its contract list
// Contract
// - Default slave address is 0x73
// - Address in upper seven bits, LSB direction
// - Device never starts a bus transfer
// - Device acks each write byte, then releases
// - Frame: address, command, data, two CRC
// - Read reply: echoed command, data, CRC
// - Error reply: command plus 0x80, code
// - Check bytes are ModBus CRC16 incl address
// - Command 0x37 changes the slave address
// - Master acks reply bytes except last
// - Every command gets a reply
`ifndef SIC_MAP_SVH
`define SIC_MAP_SVH
// ----------------------------------------------------------------------
// Addresses and codes
// ----------------------------------------------------------------------
`define SIC_DEF_ADDR 7'h73
`define SIC_CMD_SETADDR 8'h37
`define SIC_ERR_FLAG 8'h80
`define SIC_EXC_CRC 8'h03
`define SIC_IDLE_BYTE 8'hff
// ----------------------------------------------------------------------
// Frame layout and checksum
// ----------------------------------------------------------------------
`define SIC_MIN_FRAME 8'h03
`define SIC_ARG_FRAME 8'h04
`define SIC_CRC_INIT 16'hffff
`define SIC_CRC_POLY 16'ha001
`define SIC_BYTE_BITS 4'h8
`endif

// ==== pkg/sic_pkg.sv ====
// Types shared by the switch I2C command slave
`default_nettype none
package sic_pkg;
    // Bus-side sequencer states
    typedef enum logic [2:0] {
        ST_IDLE = 3'b000,
        ST_ADDR = 3'b001,
        ST_ACK = 3'b010,
        ST_WR = 3'b011,
        ST_RD = 3'b100,
        ST_MACK = 3'b101
    } sic_state_type;
endpackage : sic_pkg
`default_nettype wire

// ==== verification/sic_mst_model.sv ====
// Bus master model that drives the command slave over SCL and SDA
`default_nettype none
module sic_mst_model (
    input wire logic i_sda,  // Wired bus data level
    output logic o_scl,      // Bus clock, only the master drives it
    output logic o_sda_oe    // High while the master pulls SDA low
);
    timeunit 1ns;
    timeprecision 1ns;
    // ------------------------------------------------------------------
    // Bus timing
    // ------------------------------------------------------------------
    localparam int LO = 240; // Long low phase leaves room for ack release
    localparam int HI = 80;  // Period of 320 ns in all
    // Idle: both lines released to the pull-up, clock stands still
    initial begin
        o_scl = 1'b1;
        o_sda_oe = 1'b0;
    end
    // Start or repeated start: SDA falls while SCL is high
    task automatic start();
        o_sda_oe = 1'b0;
        #(LO/2);
        o_scl = 1'b1;
        #160;
        o_sda_oe = 1'b1;
        #160;
        o_scl = 1'b0;
    endtask : start
    // Stop: SDA rises while SCL is high, then the bus idles
    task automatic stop();
        #(LO/2);
        o_sda_oe = 1'b1;
        #(LO/2);
        o_scl = 1'b1;
        #160;
        o_sda_oe = 1'b0;
        #160;
    endtask : stop
    // One bit: data set mid low, sampled mid high
    task automatic bit_xfer(input logic b, output logic s);
        #(LO/2);
        o_sda_oe = ~b;
        #(LO/2);
        o_scl = 1'b1;
        #(HI/2);
        s = i_sda;
        #(HI/2);
        o_scl = 1'b0;
    endtask : bit_xfer
    // Byte out MSB first, then the slave's ack bit is sampled
    task automatic wr_byte(input logic [7:0] d, output logic ack);
        logic s;
        for (int i = 7; i >= 0; i--) begin
            bit_xfer(d[i], s);
        end
        bit_xfer(1'b1, s);
        ack = ~s;
    endtask : wr_byte
    // Byte in; ack all but the last, which leaves SDA high
    task automatic rd_byte(input logic last, output logic [7:0] d);
        logic s;
        for (int i = 7; i >= 0; i--) begin
            bit_xfer(1'b1, s);
            d[i] = s;
        end
        bit_xfer(last, s);
    endtask : rd_byte
endmodule : sic_mst_model
`default_nettype wire

// ==== verification/tb_top.sv ====
// Self-checking bench of the switch I2C command slave
`default_nettype none
module tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    // ------------------------------------------------------------------
    // Clock, reset, bus and reply port
    // ------------------------------------------------------------------
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic scl;
    logic m_oe;
    logic d_o, d_oe, wr_v, f_ok, f_bad;
    logic [7:0] wr_b, cmd, idx, rsp_byte;
    logic [6:0] addr;
    logic [7:0] rsp_len = 8'h00;
    logic rsp_err = 1'b0;
    logic [7:0] rsp_exc = 8'h01;
    logic [7:0] rsp_mem [4] = '{8'h02, 8'ha5, 8'h5a, 8'h00};
    logic [7:0] wq[$]; // Bytes the slave handed out
    int n_ok, n_bad, num_errors = 0, n_checks = 0;
    // Open-drain data wire with pull-up: low if anyone pulls
    wire sda = ~m_oe & (d_oe ? d_o : 1'b1);
    assign rsp_byte = rsp_mem[idx[1:0]];
    always #20 clk = ~clk;
    sic_i2c_slave u_dut (.i_clk(clk), .i_rst(rst), .i_scl(scl), .i_sda(sda),
        .o_sda_o(d_o), .o_sda_oe(d_oe), .o_wr_valid(wr_v), .o_wr_byte(wr_b),
        .o_frame_ok(f_ok), .o_frame_bad(f_bad), .o_cmd_code(cmd),
        .o_addr(addr), .o_rsp_idx(idx), .i_rsp_len(rsp_len),
        .i_rsp_byte(rsp_byte), .i_rsp_err(rsp_err), .i_rsp_exc(rsp_exc));
    sic_mst_model u_mst (.i_sda(sda), .o_scl(scl), .o_sda_oe(m_oe));
    // Record received bytes and frame verdicts
    always @(posedge clk) begin
        if (wr_v === 1'b1) wq.push_back(wr_b);
        if (f_ok === 1'b1) n_ok++;
        if (f_bad === 1'b1) n_bad++;
    end
    // ------------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------------
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        n_checks++;
        if (seen !== exp) begin
            num_errors++;
            $display("[FAIL] %0t got %h want %h", $time, seen, exp);
        end
    endtask : chk
    // Reflected 0xa001 checksum, low byte sent first
    function automatic logic [15:0] crc16(input logic [7:0] q[$]);
        logic [15:0] c;
        c = 16'hffff;
        foreach (q[i]) begin
            c ^= {8'h00, q[i]};
            for (int k = 0; k < 8; k++) c = c[0] ? (c >> 1) ^ 16'ha001 : c >> 1;
        end
        return c;
    endfunction : crc16
    task automatic set_rsp(input logic [7:0] n, input logic e,
                           input logic [7:0] x);
        @(posedge clk);
        #1;
        rsp_len = n;
        rsp_err = e;
        rsp_exc = x;
    endtask : set_rsp
    // Write frame; bad flips checksum bit 0; xa is the expected ack
    task automatic send(input logic [6:0] a, input logic [7:0] b[$],
                        input logic bad, input logic xa);
        logic [7:0] f[$];
        logic [15:0] c;
        logic ack, all;
        f = b;
        f.push_front({a, 1'b0});
        c = crc16(f) ^ {15'h0000, bad};
        f.push_back(c[7:0]);
        f.push_back(c[15:8]);
        wq.delete();
        n_ok = 0;
        n_bad = 0;
        all = 1'b1;
        @(posedge clk);
        #1;
        u_mst.start();
        foreach (f[i]) begin
            u_mst.wr_byte(f[i], ack);
            if (!ack) begin
                all = 1'b0;
                break; // Master gives up at a missing ack
            end
        end
        u_mst.stop();
        repeat (4) @(posedge clk);
        chk(all, xa);
        chk(wq.size(), xa ? f.size() - 1 : 0);
        for (int i = 0; i < wq.size() && xa; i++) chk(wq[i], f[i+1]);
        chk(n_ok, xa & ~bad);
        chk(n_bad, xa & bad);
    endtask : send
    // Read the reply and compare with code, body and checksum
    task automatic recv(input logic [6:0] a, input logic [7:0] x[$]);
        logic [7:0] f[$];
        logic [7:0] d;
        logic [15:0] c;
        logic ack;
        f = x;
        f.push_front({a, 1'b1});
        c = crc16(f);
        f.push_back(c[7:0]);
        f.push_back(c[15:8]);
        @(posedge clk);
        #1;
        u_mst.start();
        u_mst.wr_byte(f[0], ack);
        chk(ack, 1'b1);
        for (int i = 1; i < f.size(); i++) begin
            u_mst.rd_byte(i == f.size() - 1, d);
            chk(d, f[i]);
        end
        u_mst.stop();
        chk(d_oe, 1'b0);
    endtask : recv
    // ------------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------------
    task automatic t_reset();
        chk(addr, 7'h73);
        chk(d_oe, 1'b0);
    endtask : t_reset
    // Query with a three-byte body, then one with an empty body
    task automatic t_query();
        set_rsp(8'h03, 1'b0, 8'h01);
        send(7'h73, '{8'h30}, 1'b0, 1'b1);
        chk(cmd, 8'h30);
        recv(7'h73, '{8'h30, 8'h02, 8'ha5, 8'h5a});
        set_rsp(8'h00, 1'b0, 8'h01);
        send(7'h73, '{8'h78, 8'h01, 8'h05}, 1'b0, 1'b1);
        recv(7'h73, '{8'h78});
    endtask : t_query
    // Corrupt checksum, then a user error at the top of the code range
    task automatic t_errors();
        send(7'h73, '{8'h31}, 1'b1, 1'b1);
        recv(7'h73, '{8'hb1, 8'h03});
        set_rsp(8'h00, 1'b1, 8'h7f);
        send(7'h73, '{8'h33}, 1'b0, 1'b1);
        recv(7'h73, '{8'hb3, 8'h7f});
        set_rsp(8'h00, 1'b0, 8'h01);
    endtask : t_errors
    // Foreign address, then move the slave address and back
    task automatic t_addr();
        send(7'h52, '{8'h30}, 1'b0, 1'b0);
        send(7'h73, '{8'h37, 8'h21}, 1'b0, 1'b1);
        chk(addr, 7'h21);
        send(7'h73, '{8'h30}, 1'b0, 1'b0);
        send(7'h21, '{8'h30}, 1'b0, 1'b1);
        recv(7'h21, '{8'h30});
        send(7'h21, '{8'h37, 8'h73}, 1'b0, 1'b1);
        chk(addr, 7'h73);
    endtask : t_addr
    // Reset in mid-run drops a moved address; zero is never taken
    task automatic t_rst();
        send(7'h73, '{8'h37, 8'h21}, 1'b0, 1'b1);
        chk(addr, 7'h21);
        @(posedge clk);
        #1;
        rst = 1'b1;
        repeat (2) @(posedge clk);
        #1;
        rst = 1'b0;
        repeat (4) @(posedge clk);
        #1;
        chk(addr, 7'h73);
        chk(d_oe, 1'b0);
        send(7'h73, '{8'h37, 8'h00}, 1'b0, 1'b1);
        chk(addr, 7'h73);
    endtask : t_rst
    task automatic end_sim();
        $display("errors %0d checks %0d", num_errors, n_checks);
        if (num_errors == 0 && n_checks > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : end_sim
    // Main sequence: reset for 20 cycles, then the scenarios
    initial begin
        repeat (20) @(posedge clk);
        #1;
        rst = 1'b0;
        repeat (4) @(posedge clk);
        #1;
        t_reset();
        t_query();
        t_errors();
        t_addr();
        t_rst();
        end_sim();
    end
    // Watchdog: the scenarios need well under half a millisecond
    initial begin
        #1_000_000;
        num_errors++;
        end_sim();
    end
endmodule : tb_top
`default_nettype wire
